// *** rtl/bfp_timer.sv ***
// breaker failure timer block: pick-up, retrip and failure timers, wishbone
module bfp_timer
   import bfp_pkg::*;
#(
   parameter int CYCLE_CLKS = PROG_CYCLE_CLKS,
   parameter int MAG_W      = 16,
   parameter int DLY_W      = 19
) (
   // clock, reset, enable
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // measured magnitudes, same scale as the thresholds
   input  wire logic [MAG_W-1:0]  ph1_mag_i,
   input  wire logic [MAG_W-1:0]  ph2_mag_i,
   input  wire logic [MAG_W-1:0]  ph3_mag_i,
   input  wire logic [MAG_W-1:0]  res1_mag_i,
   input  wire logic [MAG_W-1:0]  res2_mag_i,
   input  wire logic [MAG_W-1:0]  calculated_residual_i,
   // trip relay monitor and blocking
   input  wire logic              trip_relay_i,
   input  wire logic              block_i,
   // outputs toward breakers and indications
   output logic                   retrip_o,
   output logic                   breaker_failure_output_o,
   output logic                   start_o,
   output logic                   blocked_o,
   // wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic [31:0]            wb_dat_o,
   output logic                   wb_ack_o
);

   localparam int DIV_W = $clog2(CYCLE_CLKS + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLE_CLKS - 1);
   localparam logic [DLY_W-1:0] CNT_MAX  = {DLY_W{1'b1}};

   typedef struct packed {
      logic [DIV_W-1:0] div;
      bfp_state_t       st;
      logic [2:0]       ph_pick;
      logic             res_pick;
      logic             timing;
      logic [DLY_W-1:0] rt_cnt;
      logic [DLY_W-1:0] bf_cnt;
      logic             start;
      logic             blocked;
      logic             retrip;
      logic             bf;
      logic             retrip_en;
      bfp_mode_t        mode;
      bfp_res_t         res_sel;
      bfp_node_t        node_mode;
      logic             allow_node;
      logic [MAG_W-1:0] ph_thr;
      logic [MAG_W-1:0] res_thr;
      logic [DLY_W-1:0] rt_dly;
      logic [DLY_W-1:0] bf_dly;
      logic             ack;
      logic [31:0]      dat;
   } bfp_regs_t;

   bfp_regs_t s;
   bfp_regs_t next_s;
   logic      tick;

   // comparator with hysteresis: picks above threshold, drops below 97 %
   // of the phase threshold, whichever input it watches
   function automatic logic cmp_pick(input logic prev,
                                     input logic [MAG_W-1:0] mag,
                                     input logic [MAG_W-1:0] thr,
                                     input logic [MAG_W-1:0] ref_thr);
      logic [31:0] lhs;
      logic [31:0] rhs;
      lhs = 32'(mag) * FULL_PCT;
      rhs = 32'(ref_thr) * DROP_PCT;
      if (prev) begin
         cmp_pick = !(lhs < rhs);
      end else begin
         cmp_pick = mag > thr;
      end
   endfunction

   // byte-lane merge of a write into a register of up to 32 bits
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      merge = (old & ~m) | (wd & m);
   endfunction

   // one program cycle tick; all protection logic steps only on it
   assign tick = ce_i && (s.div == '0);

   //////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic [31:0]      rd;
      logic [31:0]      ctl;
      logic [MAG_W-1:0] res_mag;
      logic             blk;
      logic             cur;
      logic             pick;
      logic             gate;
      logic             off;
      bfp_cond_t        cond;
      rd      = '0;
      ctl     = '0;
      res_mag = '0;
      blk     = 1'b0;
      cur     = 1'b0;
      pick    = 1'b0;
      gate    = 1'b0;
      off     = 1'b0;
      cond    = COND_NORMAL;
      next_s  = s;
      next_s.ack = 1'b0;

      // program cycle divider
      next_s.div = (s.div == '0) ? DIV_LAST : s.div - 1'b1;

      // condition value, highest event wins
      if (s.blocked) begin
         cond = COND_BLOCKED;
      end else if (s.bf) begin
         cond = COND_BF;
      end else if (s.retrip) begin
         cond = COND_RETRIP;
      end else if (s.start) begin
         cond = COND_START;
      end else if (s.node_mode != NODE_OFF) begin
         cond = COND_ON;
      end

      // register read view
      ctl[CTRL_RT_EN]          = s.retrip_en;
      ctl[CTRL_MODE +: 2]      = s.mode;
      ctl[CTRL_RES +: 2]       = s.res_sel;
      ctl[CTRL_NODE +: 3]      = s.node_mode;
      ctl[CTRL_ALLOW]          = s.allow_node;
      unique case (wb_adr_i)
         OFS_CTRL:    rd = ctl;
         OFS_PH_THR:  rd = 32'(s.ph_thr);
         OFS_RES_THR: rd = 32'(s.res_thr);
         OFS_RT_DLY:  rd = 32'(s.rt_dly);
         OFS_BF_DLY:  rd = 32'(s.bf_dly);
         OFS_STATUS: begin
            rd[STS_COND +: 3] = cond;
            if (s.allow_node) begin
               rd[STS_BEH +: 3] = s.node_mode;
               rd[STS_BEH_V]    = 1'b1;
            end
            rd[STS_START] = s.start;
            rd[STS_BLK]   = s.blocked;
            rd[STS_RT]    = s.retrip;
            rd[STS_BF]    = s.bf;
         end
         default:     rd = '0;
      endcase

      // bus: ack one cycle after the request, read data with it
      if (wb_cyc_i && wb_stb_i && !s.ack) begin
         next_s.ack = 1'b1;
         next_s.dat = rd;
      end

      // write takes effect on the edge that sees ack high
      if (wb_cyc_i && wb_stb_i && s.ack && wb_we_i) begin
         unique case (wb_adr_i)
            OFS_CTRL: begin
               ctl = merge(ctl, wb_dat_i, wb_sel_i);
               next_s.retrip_en = ctl[CTRL_RT_EN];
               next_s.mode      = bfp_mode_t'(ctl[CTRL_MODE +: 2]);
               next_s.res_sel   = bfp_res_t'(ctl[CTRL_RES +: 2]);
               next_s.node_mode = bfp_node_t'(ctl[CTRL_NODE +: 3]);
               next_s.allow_node = ctl[CTRL_ALLOW];
            end
            OFS_PH_THR: next_s.ph_thr =
               MAG_W'(merge(32'(s.ph_thr), wb_dat_i, wb_sel_i));
            OFS_RES_THR: next_s.res_thr =
               MAG_W'(merge(32'(s.res_thr), wb_dat_i, wb_sel_i));
            OFS_RT_DLY: next_s.rt_dly =
               DLY_W'(merge(32'(s.rt_dly), wb_dat_i, wb_sel_i));
            OFS_BF_DLY: next_s.bf_dly =
               DLY_W'(merge(32'(s.bf_dly), wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end

      //////////////////////////////////////////////////////////////////////
      // protection logic, once per program cycle
      if (tick) begin
         // block sampled first, everything below sees this value
         blk = block_i || (s.node_mode == NODE_BLOCKED)
                       || (s.node_mode == NODE_TST_BLK);
         off = (s.node_mode == NODE_OFF);

         // comparators with 97 % drop-out
         next_s.ph_pick[0] = cmp_pick(s.ph_pick[0], ph1_mag_i, s.ph_thr,
                                      s.ph_thr);
         next_s.ph_pick[1] = cmp_pick(s.ph_pick[1], ph2_mag_i, s.ph_thr,
                                      s.ph_thr);
         next_s.ph_pick[2] = cmp_pick(s.ph_pick[2], ph3_mag_i,
                                      s.ph_thr, s.ph_thr);
         unique case (s.res_sel)
            RES_IN1:  res_mag = res1_mag_i;
            RES_IN2:  res_mag = res2_mag_i;
            RES_CALC: res_mag = calculated_residual_i;
            default:  res_mag = '0;
         endcase
         next_s.res_pick = (s.res_sel != RES_NONE)
                        && cmp_pick(s.res_pick, res_mag, s.res_thr,
                                    s.ph_thr);
         cur = (|next_s.ph_pick) || next_s.res_pick;

         // mode-dependent pick-up and timing gate
         unique case (s.mode)
            MODE_CUR_AND: begin
               pick = cur;
               gate = trip_relay_i;
            end
            MODE_CUR_OR: begin
               pick = cur || trip_relay_i;
               gate = 1'b1;
            end
            default: begin
               pick = cur;
               gate = 1'b1;
            end
         endcase

         // start / blocked sequencing
         unique case (s.st)
            ST_IDLE: begin
               if (pick && !off) begin
                  next_s.st = blk ? ST_BLK : ST_RUN;
               end
            end
            ST_RUN: begin
               if (!pick || off) begin
                  next_s.st = ST_IDLE;
               end else if (blk) begin
                  next_s.st = ST_BLK;
               end
            end
            ST_BLK: begin
               if (!pick || off) begin
                  next_s.st = ST_IDLE;
               end
            end
            default: next_s.st = ST_IDLE;
         endcase

         // both timers share the one pick-up and gate
         next_s.timing = (next_s.st == ST_RUN) && gate;
         if (next_s.timing && s.timing) begin
            next_s.rt_cnt = (s.rt_cnt == CNT_MAX) ? s.rt_cnt
                                                  : s.rt_cnt + 1'b1;
            next_s.bf_cnt = (s.bf_cnt == CNT_MAX) ? s.bf_cnt
                                                  : s.bf_cnt + 1'b1;
         end else begin
            next_s.rt_cnt = '0;
            next_s.bf_cnt = '0;
         end

         // outputs; retrip held low when retrip is disabled
         next_s.start   = (next_s.st == ST_RUN);
         next_s.blocked = (next_s.st == ST_BLK);
         next_s.retrip  = next_s.timing && s.retrip_en
                       && (next_s.rt_cnt >= s.rt_dly);
         next_s.bf      = next_s.timing
                       && (next_s.bf_cnt >= s.bf_dly);
      end

      // synchronous reset
      if (rst_i) begin
         next_s           = '0;
         next_s.div       = DIV_LAST;
         next_s.st        = ST_IDLE;
         next_s.retrip_en = 1'b1;
         next_s.mode      = MODE_CUR;
         next_s.res_sel   = RES_NONE;
         next_s.node_mode = NODE_ON;
         next_s.ph_thr    = MAG_W'(RST_PH_THR);
         next_s.res_thr   = MAG_W'(RST_RES_THR);
         next_s.rt_dly    = DLY_W'(RST_RT_DLY);
         next_s.bf_dly    = DLY_W'(RST_BF_DLY);
      end
   end

   // state register; enable low freezes everything but reset
   always_ff @(posedge clk_i) begin
      if (rst_i || ce_i) begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign retrip_o                 = s.retrip;
   assign breaker_failure_output_o = s.bf;
   assign start_o                  = s.start;
   assign blocked_o                = s.blocked;
   assign wb_dat_o                 = s.dat;
   assign wb_ack_o                 = s.ack;

   //////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_blk_first;
      tick && s.st == ST_IDLE && (|next_s.ph_pick) && s.mode == MODE_CUR
         && block_i && s.node_mode == NODE_ON |=> blocked_o && !start_o;
   endproperty
   a_blk_first: assert property (p_blk_first)
      else $error("blocked pick-up did not raise blocked");

   property p_start;
      tick && s.st == ST_IDLE && (|next_s.ph_pick) && s.mode == MODE_CUR
         && !block_i && s.node_mode == NODE_ON |=> start_o && !blocked_o;
   endproperty
   a_start: assert property (p_start)
      else $error("pick-up did not raise start");

   property p_blk_late;
      tick && s.st == ST_RUN && block_i
         |=> !start_o && !retrip_o && !breaker_failure_output_o;
   endproperty
   a_blk_late: assert property (p_blk_late)
      else $error("late block did not release start");

   property p_rt_gate;
      $rose(retrip_o) |-> $past(s.retrip_en) && s.rt_cnt >= s.rt_dly;
   endproperty
   a_rt_gate: assert property (p_rt_gate)
      else $error("retrip rose early or while disabled");

   property p_bf_delay;
      $rose(breaker_failure_output_o) |-> s.bf_cnt >= s.bf_dly && start_o;
   endproperty
   a_bf_delay: assert property (p_bf_delay)
      else $error("failure output rose before its delay");

   property p_cur_reset;
      tick && s.mode == MODE_CUR && !(|next_s.ph_pick) && !next_s.res_pick
         |=> s.rt_cnt == '0 && s.bf_cnt == '0 && !start_o;
   endproperty
   a_cur_reset: assert property (p_cur_reset)
      else $error("timers not reset on current drop");

   property p_and_hold;
      tick && s.mode == MODE_CUR_AND && !trip_relay_i
         |=> s.rt_cnt == '0 && !retrip_o && !breaker_failure_output_o;
   endproperty
   a_and_hold: assert property (p_and_hold)
      else $error("timers ran without trip relay");

   property p_or_hold;
      tick && s.mode == MODE_CUR_OR && s.st == ST_RUN && trip_relay_i
         && !block_i && s.node_mode == NODE_ON |=> start_o;
   endproperty
   a_or_hold: assert property (p_or_hold)
      else $error("relay alone did not keep pick-up");

   property p_tick_only;
      !tick |=> $stable(s.rt_cnt) && $stable(s.st);
   endproperty
   a_tick_only: assert property (p_tick_only)
      else $error("timer moved between program cycles");

   c_retrip:  cover property ($rose(retrip_o));
   c_bf:      cover property ($rose(breaker_failure_output_o));
   c_blocked: cover property ($rose(blocked_o));
   c_late:    cover property (start_o ##1 blocked_o);

endmodule

// *** rtl/bfp_pkg.sv ***
// constants and types for the breaker failure timer block
package bfp_pkg;

   // timing
   localparam int CLK_PERIOD_NS  = 50;
   localparam int PROG_CYCLE_NS  = 5_000_000;
   localparam int PROG_CYCLE_CLKS = PROG_CYCLE_NS / CLK_PERIOD_NS;
   localparam int STEP_MS        = 5;
   localparam int RETRIP_DLY_MS  = 100;
   localparam int BF_DLY_MS      = 200;
   localparam int BLOCK_LEAD_MS  = 5;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_PH_THR  = 8'h04;
   localparam logic [7:0] OFS_RES_THR = 8'h08;
   localparam logic [7:0] OFS_RT_DLY  = 8'h0C;
   localparam logic [7:0] OFS_BF_DLY  = 8'h10;
   localparam logic [7:0] OFS_STATUS  = 8'h14;

   // control register fields
   localparam int CTRL_RT_EN = 0;
   localparam int CTRL_MODE  = 1;
   localparam int CTRL_RES   = 3;
   localparam int CTRL_NODE  = 5;
   localparam int CTRL_ALLOW = 8;

   // status register fields
   localparam int STS_COND  = 0;
   localparam int STS_BEH   = 4;
   localparam int STS_BEH_V = 7;
   localparam int STS_START = 8;
   localparam int STS_BLK   = 9;
   localparam int STS_RT    = 10;
   localparam int STS_BF    = 11;

   // reset values
   localparam logic [15:0] RST_PH_THR   = 16'h0014;
   localparam logic [15:0] RST_RES_THR  = 16'h04B0;
   localparam logic [18:0] RST_RT_DLY   = 19'(RETRIP_DLY_MS / STEP_MS);
   localparam logic [18:0] RST_BF_DLY   = 19'(BF_DLY_MS / STEP_MS);

   // comparator hysteresis, drop-out ratio in percent
   localparam logic [31:0] DROP_PCT = 32'h0000_0061;
   localparam logic [31:0] FULL_PCT = 32'h0000_0064;

   typedef enum logic [1:0] {
      MODE_CUR     = 2'h0,
      MODE_CUR_AND = 2'h1,
      MODE_CUR_OR  = 2'h2
   } bfp_mode_t;

   typedef enum logic [1:0] {
      RES_NONE = 2'h0,
      RES_IN1  = 2'h1,
      RES_IN2  = 2'h2,
      RES_CALC = 2'h3
   } bfp_res_t;

   typedef enum logic [2:0] {
      NODE_ON      = 3'h0,
      NODE_BLOCKED = 3'h1,
      NODE_TEST    = 3'h2,
      NODE_TST_BLK = 3'h3,
      NODE_OFF     = 3'h4
   } bfp_node_t;

   typedef enum logic [2:0] {
      COND_NORMAL  = 3'h0,
      COND_START   = 3'h1,
      COND_RETRIP  = 3'h2,
      COND_BF      = 3'h3,
      COND_ON      = 3'h4,
      COND_BLOCKED = 3'h5
   } bfp_cond_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_BLK  = 3'b100
   } bfp_state_t;

endpackage

// *** verif/bfp_prim_relay_model.sv ***
// primary protection trip relay seen by the breaker failure block
module bfp_prim_relay_model (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // fault seen by the primary stage, trip delay in clocks
   input  wire logic       fault_i,
   input  wire logic [7:0] delay_i,
   // monitored relay contact
   output logic            trip_relay_o
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0] cnt;

   // relay energises after its own operate delay, drops at once
   // when the fault clears, so short faults never reach the contact
   always_ff @(posedge clk_i) begin
      if (rst_i || !fault_i) begin
         cnt          <= 8'h00;
         trip_relay_o <= 1'b0;
      end else if (cnt == delay_i) begin
         trip_relay_o <= 1'b1;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

// *** verif/tb.sv ***
// self-checking bench for the breaker failure timer block
`define CHK(a, e) \
   begin \
      n_tests++; \
      if ((a) !== (e)) begin \
         mismatches++; \
         $display("MISMATCH t=%0t value differs", $time); \
      end \
   end
module tb;
   import bfp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int CYC = 8;
   localparam int RT  = 3;
   localparam int BF  = 6;
   localparam logic [15:0] THR = 16'h0064;

   logic        clk_i;
   logic        rst_i = 1'b1;
   logic [15:0] ph [3] = '{16'h0000, 16'h0000, 16'h0000};
   logic [15:0] res1 = 16'h0000;
   logic [15:0] res2 = 16'h0000;
   logic [15:0] calc = 16'h0000;
   logic        fault = 1'b0;
   logic        blk = 1'b0;
   logic        relay;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        retrip_o;
   logic        bf_o;
   logic        start_o;
   logic        blocked_o;
   logic        go = 1'b0;
   integer      seed = 39;
   int          mismatches = 0;
   int          n_tests = 0;
   int          ecnt = 0;
   int          n_cyc = 0;
   int          mst = 0;
   int          mcnt = 0;
   logic        mrun;
   logic [2:0]  ph_a;
   logic        rs_a;
   logic [1:0]  m_mode = 2'h0;
   logic [1:0]  m_res = 2'h0;
   logic        m_rt = 1'b1;
   logic        e_st, e_bk, e_rt, e_bf;

   bfp_timer #(.CYCLE_CLKS(CYC)) bfp_timer_i (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .ph1_mag_i(ph[0]), .ph2_mag_i(ph[1]), .ph3_mag_i(ph[2]),
      .res1_mag_i(res1), .res2_mag_i(res2),
      .calculated_residual_i(calc),
      .trip_relay_i(relay), .block_i(blk),
      .retrip_o(retrip_o), .breaker_failure_output_o(bf_o),
      .start_o(start_o), .blocked_o(blocked_o),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o));

   bfp_prim_relay_model bfp_prim_relay_model_i (
      .clk_i(clk_i), .rst_i(rst_i), .fault_i(fault),
      .delay_i(8'h14), .trip_relay_o(relay));

   ////////////////////////////////////////////////////////////////
   // clock, timeout, verdict
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   task automatic wrap_up();
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ceiling well above the six segments of traffic
   always @(posedge clk_i) begin
      n_cyc++;
      if (n_cyc == 40000) begin
         mismatches++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////
   // reference model, evaluated once per program tick
   function automatic logic hy(logic a, logic [15:0] m, logic [15:0] t);
      return a ? (32'(m) * 100 >= 32'(t) * 97) : (m > t);
   endfunction

   task automatic tick_eval();
      logic [15:0] rm;
      logic cur, pick, en;
      rm = (m_res == 2'h1) ? res1 : (m_res == 2'h2) ? res2 : calc;
      for (int k = 0; k < 3; k++) ph_a[k] = hy(ph_a[k], ph[k], THR);
      rs_a = (m_res != 2'h0) && hy(rs_a, rm, THR);
      cur = (|ph_a) | rs_a;
      pick = (m_mode == 2'h2) ? (cur | relay) : cur;
      en = (m_mode == 2'h1) ? relay : 1'b1;
      if (mst == 0 && pick) begin
         mst = blk ? 2 : 1;
         mcnt = 0;
         mrun = en;
      end else if (mst != 0 && !pick) begin
         mst = 0;
      end else if (mst == 1 && blk) begin
         mst = 2;
      end else if (mst == 1) begin
         mcnt = (en && mrun) ? mcnt + 1 : 0;
         mrun = en;
      end
      e_st = (mst == 1);
      e_bk = (mst == 2);
      e_rt = e_st && mrun && m_rt && mcnt >= RT;
      e_bf = e_st && mrun && mcnt >= BF;
   endtask

   always @(posedge clk_i) begin
      if (rst_i) begin
         ecnt = 0;
         mst = 0;
         ph_a = 3'h0;
         rs_a = 1'b0;
         {e_st, e_bk, e_rt, e_bf} = 4'h0;
      end else begin
         ecnt++;
         if (ecnt % CYC == 0) tick_eval();
      end
   end

   // outputs are registered, so the settled value is seen mid-cycle
   always @(negedge clk_i) begin
      if (!rst_i) begin
         `CHK(start_o, e_st)
         `CHK(blocked_o, e_bk)
         `CHK(retrip_o, e_rt)
         `CHK(bf_o, e_bf)
      end
   end

   ////////////////////////////////////////////////////////////////
   // random stimulus; magnitudes sit clear of the thresholds or
   // inside the hysteresis band, never on an edge of it
   function automatic logic [15:0] mag_pick();
      case ($random(seed) & 3)
         0: return 16'h000A;
         1: return 16'h0062;
         2: return 16'h00C8;
         default: return 16'h0000;
      endcase
   endfunction

   always @(posedge clk_i) begin
      if (!go) begin
         ph <= '{16'h0000, 16'h0000, 16'h0000};
         {res1, res2, calc} <= 48'h0;
         fault <= 1'b0;
         blk <= 1'b0;
      end else if (($random(seed) & 63) == 0) begin
         for (int k = 0; k < 3; k++) ph[k] <= mag_pick();
         res1 <= mag_pick();
         res2 <= mag_pick();
         calc <= mag_pick();
         fault <= 1'($random(seed));
         if (($random(seed) & 7) == 0) blk <= !blk;
      end
   end

   ////////////////////////////////////////////////////////////////
   // classic wishbone single cycle, data taken at the ack edge
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   initial begin
      logic [31:0] q;
      logic [2:0] ec;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, OFS_CTRL, 32'h0, q);
      `CHK(q, 32'h0000_0001)
      wb(1'b0, OFS_PH_THR, 32'h0, q);
      `CHK(q, 32'(RST_PH_THR))
      wb(1'b0, OFS_RES_THR, 32'h0, q);
      `CHK(q, 32'(RST_RES_THR))
      wb(1'b0, OFS_RT_DLY, 32'h0, q);
      `CHK(q, 32'(RST_RT_DLY))
      wb(1'b0, OFS_BF_DLY, 32'h0, q);
      `CHK(q, 32'(RST_BF_DLY))
      wb(1'b1, OFS_STATUS, 32'hFFFF_FFFF, q);
      wb(1'b1, 8'h18, 32'hFFFF_FFFF, q);
      wb(1'b0, 8'h18, 32'h0, q);
      `CHK(q, 32'h0000_0000)
      wb(1'b0, OFS_STATUS, 32'h0, q);
      `CHK(q, 32'(COND_ON))
      wb(1'b1, OFS_CTRL, 32'h0000_0101, q);
      wb(1'b0, OFS_STATUS, 32'h0, q);
      `CHK(q[7:4], {1'b1, NODE_ON})
      wb(1'b1, OFS_PH_THR, 32'(THR), q);
      wb(1'b1, OFS_RES_THR, 32'(THR), q);
      // failure delay just beyond retrip plus relay time
      wb(1'b1, OFS_RT_DLY, RT, q);
      wb(1'b1, OFS_BF_DLY, BF, q);
      // every mode and residual source, retrip on then off
      for (int i = 0; i < 6; i++) begin
         go <= 1'b0;
         repeat (40) @(posedge clk_i);
         m_mode = 2'(i % 3);
         m_res = 2'(i % 4);
         m_rt = (i < 3);
         wb(1'b1, OFS_CTRL, 32'({m_res, m_mode, m_rt}), q);
         go <= 1'b1;
         repeat (20) begin
            repeat (100) @(posedge clk_i);
            do @(negedge clk_i); while (ecnt % CYC != 1);
            wb(1'b0, OFS_STATUS, 32'h0, q);
            ec = (mst == 0) ? COND_ON : (mst == 2) ? COND_BLOCKED :
                 e_bf ? COND_BF : e_rt ? COND_RETRIP : COND_START;
            `CHK(q[11:0], {e_bf, e_rt, e_bk, e_st, 5'h00, ec})
         end
      end
      wrap_up();
   end
endmodule
